// file: rtl/tpwm_regs.svh
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
`define TPWM_OFS_GLOBAL_INTERRUPT_CONTROL     8'h0b
`define TPWM_OFS_FLAGS      8'h0c
`define TPWM_OFS_COUNT      8'h11
`define TPWM_OFS_TCTRL      8'h12
`define TPWM_OFS_DUTYW      8'h15
`define TPWM_OFS_DUTYA      8'h16
`define TPWM_OFS_MCTRL      8'h17
`define TPWM_OFS_PORTC      8'h07
`define TPWM_OFS_PORTDIR    8'h87
`define TPWM_OFS_ENABLES    8'h8c
`define TPWM_OFS_LIMIT      8'h92
`define TPWM_RST_LIMIT      8'hff
`define TPWM_RST_PORTDIR    8'hff
`define TPWM_BIT_TMR_FLAG   1
`define TPWM_BIT_TIMER_RUN  2
`define TPWM_BIT_PIN        2
`define TPWM_TCTRL_MASK     8'h7f
`define TPWM_MCTRL_MASK     8'h3f
`define TPWM_FLAGS_MASK     8'h4f
`define TPWM_QPHASE_CYCLES  4
`endif

// file: rtl/tpwm_pkg.sv
package tpwm_pkg;
  typedef enum logic [2:0] {
    TPWM_BUS_IDLE = 3'b001,
    TPWM_BUS_ACK  = 3'b010,
    TPWM_BUS_DONE = 3'b100
  } tpwm_bus_st_t;
  typedef enum logic [1:0] {
    TPWM_PS_DIV1  = 2'b00,
    TPWM_PS_DIV4  = 2'b01,
    TPWM_PS_DIV16 = 2'b10
  } tpwm_ps_t;
endpackage : tpwm_pkg

// file: rtl/tpwm_tick_if.sv
`timescale 1ns/1ps
// Timing between the prescaler and the pulse core
interface tpwm_tick_if;
  logic       inc;
  logic [1:0] sub;
  logic [1:0] ps_sel;
  logic       run;
  logic       clr;
  modport pre  (output inc, output sub, input ps_sel, input run, input clr);
  modport core (input inc, input sub, output ps_sel, output run, output clr);
endinterface : tpwm_tick_if

// file: rtl/tpwm_prescale.sv
`timescale 1ns/1ps
`include "tpwm_regs.svh"
module tpwm_prescale (
  input  wire logic  mclk,
  input  wire logic  rst,
  tpwm_tick_if.pre   tk
);
  import tpwm_pkg::*;
  // Phase counter: mclk is the oscillator, four phases per instruction cycle
  logic [1:0] q_q;
  logic [3:0] pre_q;
  logic [3:0] lim;

  always_comb begin
    case (tk.ps_sel)
      2'b00:   lim = 4'h0;
      2'b01:   lim = 4'h3;
      default: lim = 4'hf;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_q <= 2'h0;
    end else if (tk.clr || !tk.run) begin
      q_q <= 2'h0;
    end else begin
      q_q <= q_q + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_q <= 4'h0;
    end else if (tk.clr || !tk.run) begin
      pre_q <= 4'h0;
    end else if (q_q == 2'h3) begin
      pre_q <= (pre_q >= lim) ? 4'h0 : pre_q + 4'h1;
    end
  end

  assign tk.inc = tk.run && !tk.clr && (q_q == 2'h3) && (pre_q >= lim);
  // Two low compare bits: Q phase at 1:1, pre_q[1:0] at 1:4, else top prescaler bits pre_q[3:2]
  always_comb begin
    case (tk.ps_sel)
      2'b00:   tk.sub = q_q;
      2'b01:   tk.sub = pre_q[1:0];
      default: tk.sub = pre_q[3:2];
    endcase
  end
endmodule : tpwm_prescale

// file: rtl/tpwm_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tpwm_regs.svh"
module tpwm_top #(
  parameter int POST_W = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic             pulse_output_pin_o,
  output logic             pulse_output_pin_oe,
  output logic             period_timer_flag
);
  import tpwm_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] period_limit_q;
  logic [7:0] period_timer_count_q;
  logic [7:0] period_timer_control_q;
  logic [7:0] duty_write_byte_q;
  logic [7:0] duty_active_byte_q;
  logic [1:0] duty_low_latch_q;
  logic [7:0] module_control_q;
  logic [7:0] port_c_direction_q;
  logic [7:0] port_c_data_q;
  logic [7:0] global_interrupt_control_q;
  logic [7:0] peripheral_interrupt_flags_q;
  logic [7:0] peripheral_interrupt_enables_q;
  logic       pulse_latch_q;
  logic [POST_W-1:0] post_q;
  tpwm_bus_st_t      bus_q;
  logic [31:0]       rdata_q;
  logic [1:0]        resp_q;

  tpwm_tick_if tk ();

  tpwm_prescale u_pre (
    .mclk (mclk),
    .rst  (rst),
    .tk   (tk.pre)
  );

  logic       pwm_mode;
  logic       wr_acc;
  logic       match;
  logic       tick;
  logic [9:0] duty_now;
  logic [9:0] count_ext;
  logic       mctrl_zero_wr;
  logic       hit;

  assign pwm_mode   = module_control_q[3:2] == 2'b11;
  assign tk.run     = period_timer_control_q[`TPWM_BIT_TIMER_RUN];
  assign tk.ps_sel  = period_timer_control_q[1:0];
  assign tick       = tk.inc;
  assign match      = period_timer_count_q == period_limit_q;
  assign duty_now   = {duty_active_byte_q, duty_low_latch_q};
  assign count_ext  = {period_timer_count_q, tk.sub};
  assign wr_acc     = (bus_q == TPWM_BUS_IDLE) && avs_write && avs_byteenable[0];

  // Byte writes to a register, decoded once
  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_acc && (avs_address == ofs);
  endfunction : wr_to

  assign mctrl_zero_wr = wr_to(`TPWM_OFS_MCTRL) && (avs_writedata[7:0] == 8'h00);
  // Timer writes restart the phase so the compare stays aligned
  assign tk.clr = wr_to(`TPWM_OFS_COUNT) || wr_to(`TPWM_OFS_TCTRL);

  // ------------------------------------------------------------
  // Avalon slave: one wait cycle, answer in ACK state
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_q <= TPWM_BUS_IDLE;
    end else begin
      case (bus_q)
        TPWM_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= TPWM_BUS_ACK;
          end
        end
        TPWM_BUS_ACK:  bus_q <= TPWM_BUS_DONE;
        TPWM_BUS_DONE: bus_q <= TPWM_BUS_IDLE;
        default:       bus_q <= TPWM_BUS_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_q != TPWM_BUS_ACK);
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
      resp_q  <= 2'h0;
    end else if (bus_q == TPWM_BUS_IDLE && (avs_read || avs_write)) begin
      resp_q  <= 2'h0;
      rdata_q <= 32'h0;
      case (avs_address)
        `TPWM_OFS_GLOBAL_INTERRUPT_CONTROL:  rdata_q[7:0] <= global_interrupt_control_q;
        `TPWM_OFS_FLAGS:   rdata_q[7:0] <= peripheral_interrupt_flags_q;
        `TPWM_OFS_COUNT:   rdata_q[7:0] <= period_timer_count_q;
        `TPWM_OFS_TCTRL:   rdata_q[7:0] <= period_timer_control_q;
        `TPWM_OFS_DUTYW:   rdata_q[7:0] <= duty_write_byte_q;
        `TPWM_OFS_DUTYA:   rdata_q[7:0] <= duty_active_byte_q;
        `TPWM_OFS_MCTRL:   rdata_q[7:0] <= module_control_q;
        `TPWM_OFS_PORTC:   rdata_q[7:0] <= port_c_data_q;
        `TPWM_OFS_PORTDIR: rdata_q[7:0] <= port_c_direction_q;
        `TPWM_OFS_ENABLES: rdata_q[7:0] <= peripheral_interrupt_enables_q;
        `TPWM_OFS_LIMIT:   rdata_q[7:0] <= period_limit_q;
        default:           resp_q <= 2'h2;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      period_limit_q         <= `TPWM_RST_LIMIT;
      period_timer_control_q <= 8'h00;
      duty_write_byte_q      <= 8'h00;
      module_control_q       <= 8'h00;
      port_c_direction_q     <= `TPWM_RST_PORTDIR;
      port_c_data_q          <= 8'h00;
      global_interrupt_control_q     <= 8'h00;
      peripheral_interrupt_enables_q <= 8'h00;
    end else begin
      if (wr_to(`TPWM_OFS_LIMIT)) period_limit_q <= avs_writedata[7:0];
      if (wr_to(`TPWM_OFS_TCTRL)) period_timer_control_q <= avs_writedata[7:0] & `TPWM_TCTRL_MASK;
      if (wr_to(`TPWM_OFS_DUTYW)) duty_write_byte_q <= avs_writedata[7:0];
      if (wr_to(`TPWM_OFS_MCTRL)) module_control_q <= avs_writedata[7:0] & `TPWM_MCTRL_MASK;
      if (wr_to(`TPWM_OFS_PORTDIR)) port_c_direction_q <= avs_writedata[7:0];
      if (wr_to(`TPWM_OFS_PORTC)) port_c_data_q <= avs_writedata[7:0];
      if (wr_to(`TPWM_OFS_GLOBAL_INTERRUPT_CONTROL)) global_interrupt_control_q <= avs_writedata[7:0];
      if (wr_to(`TPWM_OFS_ENABLES)) peripheral_interrupt_enables_q <= avs_writedata[7:0] & `TPWM_FLAGS_MASK;
    end
  end

  // ------------------------------------------------------------
  // Period timer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      period_timer_count_q <= 8'h00;
    end else if (wr_to(`TPWM_OFS_COUNT)) begin
      period_timer_count_q <= avs_writedata[7:0];
    end else if (tick) begin
      period_timer_count_q <= match ? 8'h00 : period_timer_count_q + 8'h01;
    end
  end

  // Active buffer loads only at period end; bus writes ignored in pulse mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      duty_active_byte_q <= 8'h00;
      duty_low_latch_q   <= 2'h0;
    end else if (tick && match) begin
      duty_active_byte_q <= duty_write_byte_q;
      duty_low_latch_q   <= module_control_q[5:4];
    end else if (wr_to(`TPWM_OFS_DUTYA) && !pwm_mode) begin
      duty_active_byte_q <= avs_writedata[7:0];
    end
  end

  // Postscaler paces only the flag, the period ignores it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      post_q <= '0;
    end else if (wr_to(`TPWM_OFS_TCTRL)) begin
      post_q <= '0;
    end else if (tick && match) begin
      post_q <= (post_q >= POST_W'(period_timer_control_q[6:3])) ? '0 : post_q + POST_W'(1);
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      peripheral_interrupt_flags_q <= 8'h00;
    end else begin
      if (wr_to(`TPWM_OFS_FLAGS)) peripheral_interrupt_flags_q <= avs_writedata[7:0] & `TPWM_FLAGS_MASK;
      if (tick && match && post_q >= POST_W'(period_timer_control_q[6:3])) begin
        peripheral_interrupt_flags_q[`TPWM_BIT_TMR_FLAG] <= 1'b1;
      end
    end
  end
  assign period_timer_flag = peripheral_interrupt_flags_q[`TPWM_BIT_TMR_FLAG];

  // ------------------------------------------------------------
  // Pulse latch
  // ------------------------------------------------------------
  // The low-going compare uses the buffered duty; a duty longer than
  // the period never matches, so the pin stays high.
  assign hit = duty_now == count_ext;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_latch_q <= 1'b0;
    end else if (mctrl_zero_wr || !pwm_mode) begin
      pulse_latch_q <= 1'b0;
    end else if (tick && match) begin
      pulse_latch_q <= {duty_write_byte_q, module_control_q[5:4]} != 10'h000;
    end else if (tk.run && hit) begin
      pulse_latch_q <= 1'b0;
    end
  end

  // Pin mux: pulse latch in pulse mode, else the untouched port latch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_output_pin_o  <= 1'b0;
      pulse_output_pin_oe <= 1'b0;
    end else begin
      // Masking with the live compare makes the on-time exactly duty cycles,
      // the latch clears on that same edge, so through the register alone the pin would fall one edge later
      pulse_output_pin_o  <= pwm_mode ? (pulse_latch_q && !(tk.run && hit))
                                      : port_c_data_q[`TPWM_BIT_PIN];
      pulse_output_pin_oe <= !port_c_direction_q[`TPWM_BIT_PIN];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_count_clear: assert property (@(posedge mclk) disable iff (rst)
    (tick && match && !tk.clr) |=> period_timer_count_q == 8'h00)
    else $error("timer not cleared after match");
  chk_duty_load: assert property (@(posedge mclk) disable iff (rst)
    (tick && match) |=> duty_active_byte_q == $past(duty_write_byte_q))
    else $error("duty not loaded at period end");
  chk_pin_set: assert property (@(posedge mclk) disable iff (rst)
    (tick && match && pwm_mode && !mctrl_zero_wr && duty_write_byte_q != 8'h00) |=> pulse_latch_q)
    else $error("pin not set at period start");
  chk_zero_duty: assert property (@(posedge mclk) disable iff (rst)
    (tick && match && {duty_write_byte_q, module_control_q[5:4]} == 10'h000) |=> !pulse_latch_q)
    else $error("pin set with zero duty");
  chk_ctrl_zero: assert property (@(posedge mclk) disable iff (rst)
    mctrl_zero_wr |=> !pulse_latch_q)
    else $error("control clear left latch high");
  chk_ro_active: assert property (@(posedge mclk) disable iff (rst)
    (pwm_mode && !(tick && match)) |=> $stable(duty_active_byte_q))
    else $error("active duty changed mid-period");
  chk_hit_low: assert property (@(posedge mclk) disable iff (rst)
    (pwm_mode && tk.run && hit && !(tick && match) && !mctrl_zero_wr) |=> !pulse_latch_q)
    else $error("pin not cleared at duty match");
  chk_pin_low: assert property (@(posedge mclk) disable iff (rst)
    (pwm_mode && tk.run && hit) |=> !pulse_output_pin_o)
    else $error("pin high at duty match");
  chk_mode_off: assert property (@(posedge mclk) disable iff (rst)
    !pwm_mode |=> !pulse_latch_q)
    else $error("latch high outside pulse mode");
  chk_bus_ack: assert property (@(posedge mclk) disable iff (rst)
    (bus_q == TPWM_BUS_IDLE && avs_read) |=> !avs_waitrequest)
    else $error("read not answered in one wait cycle");
endmodule : tpwm_top

// file: testbench/tpwm_load.sv
`timescale 1ns/1ps
// ----------------------------------------
// Load on the pulse pin, pulled down
// ----------------------------------------
module tpwm_load (
  input  wire logic mclk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output int        high_len,
  output int        period_len,
  output int        rises
);
  logic lvl;
  logic prev;
  int   hc;
  int   pc;
  // A released pin falls to the pull-down, never the last driven value
  assign lvl = pin_oe ? pin_o : 1'b0;
  initial begin
    prev = 1'b0; hc = 0; pc = 0; high_len = 0; period_len = 0; rises = 0;
  end
  always @(posedge mclk) begin
    prev <= lvl;
    if (lvl && !prev) begin
      period_len <= pc;
      pc         <= 1;
      hc         <= 1;
      rises      <= rises + 1;
    end else begin
      pc <= pc + 1;
      if (lvl) hc <= hc + 1;
    end
    if (!lvl && prev) high_len <= hc;
  end
endmodule : tpwm_load

// file: testbench/timer_based_pwm_output_test.sv
`timescale 1ns/1ps
`include "tpwm_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer_based_pwm_output_test;
  logic        mclk, rst, avs_read, avs_write;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, pin_o, pin_oe, tflag;
  logic [1:0]  avs_response;
  int          high_len, period_len, rises, n_mismatch, compares;
  logic [7:0]  rd;
  logic [1:0]  rsp;

  tpwm_top dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .pulse_output_pin_o(pin_o), .pulse_output_pin_oe(pin_oe), .period_timer_flag(tflag));
  tpwm_load u_load (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .high_len(high_len),
    .period_len(period_len), .rises(rises));

  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic bus_xfer(input logic [7:0] a, input logic [7:0] d, input logic wr);
    int n;
    logic ws;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    // Sample the settled answer before the edge that completes the transfer
    do begin
      @(negedge mclk);
      ws  = avs_waitrequest;
      rd  = avs_readdata[7:0];
      rsp = avs_response;
      @(posedge mclk);
      n++;
    end while (ws !== 1'b0 && n < 50);
    if (n >= 50) `CHK(1'b0, 1'b1)
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus_xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_xfer(a, d, 1'b1);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus_xfer(a, 8'h00, 1'b0);
    `CHK(rd, e)
  endtask : rd_chk
  // Waits for n fresh rising edges on the pin, bounded
  task automatic wait_rises(input int n);
    int s, k;
    s = rises;
    k = 0;
    while (rises < s + n && k < 40000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 40000) `CHK(1'b0, 1'b1)
  endtask : wait_rises
  task automatic count_high(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge mclk);
      if (pin_o === 1'b1) hi++;
    end
  endtask : count_high

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    rd_chk(`TPWM_OFS_LIMIT, 8'hff);
    rd_chk(`TPWM_OFS_PORTDIR, 8'hff);
    rd_chk(`TPWM_OFS_MCTRL, 8'h00);
    rd_chk(`TPWM_OFS_TCTRL, 8'h00);
    rd_chk(`TPWM_OFS_COUNT, 8'h00);
    bus_xfer(8'h50, 8'h00, 1'b0);
    `CHK(rsp, 2'b10)
    `CHK(pin_oe, 1'b0)
  endtask : t_reset_vals
  task automatic t_setup();
    wr(`TPWM_OFS_LIMIT, 8'h09);
    wr(`TPWM_OFS_DUTYW, 8'h05);
    wr(`TPWM_OFS_PORTDIR, 8'hfb);
    wr(`TPWM_OFS_PORTC, 8'h04);
    wr(`TPWM_OFS_TCTRL, 8'h04);
    wr(`TPWM_OFS_MCTRL, 8'h2c);
    `CHK(pin_oe, 1'b1)
  endtask : t_setup
  task automatic t_low_bits();
    for (int lb = 0; lb < 4; lb++) begin
      wr(`TPWM_OFS_MCTRL, {2'b00, lb[1:0], 4'hc});
      wait_rises(3);
      `CHK(high_len, 20 + lb)
      `CHK(period_len, 40)
    end
    rd_chk(`TPWM_OFS_DUTYA, 8'h05);
  endtask : t_low_bits
  task automatic t_prescale();
    for (int p = 0; p < 3; p++) begin
      wr(`TPWM_OFS_TCTRL, 8'h04 | p[7:0]);
      wait_rises(3);
      `CHK(period_len, 40 << (2 * p))
      `CHK(high_len, 23 << (2 * p))
    end
  endtask : t_prescale
  task automatic t_postscale();
    wr(`TPWM_OFS_TCTRL, 8'h7c);
    wait_rises(3);
    `CHK(period_len, 40)
    wait_rises(17);
    `CHK(tflag, 1'b1)
    wr(`TPWM_OFS_TCTRL, 8'h04);
  endtask : t_postscale
  task automatic t_buffer();
    wait_rises(1);
    wr(`TPWM_OFS_DUTYW, 8'h08);
    rd_chk(`TPWM_OFS_DUTYA, 8'h05);
    wait_rises(3);
    `CHK(high_len, 35)
    rd_chk(`TPWM_OFS_DUTYA, 8'h08);
    wr(`TPWM_OFS_DUTYA, 8'h77);
    rd_chk(`TPWM_OFS_DUTYA, 8'h08);
    wait_rises(2);
    `CHK(high_len, 35)
  endtask : t_buffer
  task automatic t_over_and_zero();
    int hi;
    wr(`TPWM_OFS_DUTYW, 8'h0b);
    // An over-long duty rises once and then never falls again
    wait_rises(1);
    count_high(100, hi);
    `CHK(hi, 100)
    wr(`TPWM_OFS_DUTYW, 8'h00);
    wr(`TPWM_OFS_MCTRL, 8'h0c);
    repeat (90) @(posedge mclk);
    count_high(120, hi);
    `CHK(hi, 0)
  endtask : t_over_and_zero
  task automatic t_clear();
    wr(`TPWM_OFS_DUTYW, 8'h05);
    wr(`TPWM_OFS_MCTRL, 8'h2c);
    wait_rises(3);
    wr(`TPWM_OFS_MCTRL, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK(pin_o, 1'b1)
    rd_chk(`TPWM_OFS_PORTC, 8'h04);
    wr(`TPWM_OFS_PORTC, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK(pin_o, 1'b0)
  endtask : t_clear

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic report_and_stop();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    n_mismatch = 0; compares = 0; rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h0; avs_byteenable = 4'hf;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset_vals();
    t_setup();
    t_low_bits();
    t_prescale();
    t_postscale();
    t_buffer();
    t_over_and_zero();
    t_clear();
    report_and_stop();
  end
endmodule : timer_based_pwm_output_test
